// ---- design/mcsr_regs.sv ----
// modem control and status register bank with axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
// Operation
// - terminal-ready low over 50 ms starts disconnect
// - request-to-send bit stored, read back, unused
// - control bit 2 drives user output a reset
// - control bit 3 enables interrupt output drive
// - control bit 4 selects digital loopback
// - control bits 5 and 6 read zero
// - control bit 7 selects register bank
// - five-level interrupt priority with fixed codes
// - line errors raise interrupt, cleared by read
// - status bit 0 flags clear-to-send change
// - status bit 1 flags set-ready change
// - status bit 2 flags ring low-to-high
// - status bit 3 flags carrier indication change
// - status bit 4 set on connection done
// - status bit 5 follows power state
// - loopback: status bit 5 mirrors terminal-ready
// - status bit 6 inverted ring, loopback reset bit
// - status bit 7 qualified carrier after time
// - tone detector enabled: bit 7 shows tones
// - loopback: status bit 7 mirrors interrupt enable
// - scratch byte free read/write, no effect
// - ident bit 0 low while interrupt pending
module mcsr_regs
  import mcsr_pkg::*;
#(
  parameter int DTR_LOSS_CYCLES = DTR_LOSS_CYC_DEF // shorten for simulation
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // modem side levels
  input wire logic connect_done,
  input wire logic power_up,
  input wire logic ring_in,
  input wire logic carrier_valid,
  input wire logic tone_detect_en,
  input wire logic tone_present,
  // interrupt sources from the rest of the controller
  input wire logic [3:0] line_err_pulse,
  input wire logic rx_data_avail,
  input wire logic thre_set_pulse,
  input wire logic thr_write_pulse,
  input wire logic ms1_pending,
  // control outputs
  output logic dtr_disconnect,
  output logic user_output_a_reset,
  output logic loopback_mode,
  output logic bank_select,
  // interrupt pin
  output logic irq_output,
  output logic irq_output_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] mc_q; // modem_control_two
  logic [7:0] scratch_q; // scratch_store
  logic [3:0] ien_q; // interrupt enables
  logic [3:0] lerr_q; // sticky line errors
  logic [3:0] delta_q; // status change flags
  logic thre_pend_q; // transmit holding empty pending
  logic cts_prev_q; // last live clear-to-send
  logic dsr_prev_q; // last live set-ready
  logic ri_prev_q; // last ring input
  logic cd_prev_q; // last live carrier indication
  logic [12:0] cd_cnt_q; // carrier qualify counter
  logic cd_qual_q; // carrier qualified
  mcsr_dtr_e dtr_st_q; // terminal-ready loss state
  logic [31:0] dtr_cnt_q; // terminal-ready low time
  logic cts_live, dsr_live, ri_live, cd_live; // live status levels
  logic [7:0] mstat; // assembled status byte
  logic [3:0] iir_code; // current interrupt code
  logic wr_go, rd_go; // bus accepts
  logic wr_mc, wr_scr, wr_ien; // write decodes
  logic rd_ms, rd_iir, rd_ls; // read decodes with side effects
  logic ms_pend, ls_pend; // derived pending levels
  logic [3:0] delta_set; // change events this cycle

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel: take address and data together
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  assign wr_mc = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFS_MCTL);
  assign wr_scr = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFS_SCRATCH);
  assign wr_ien = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFS_IEN);

  // ready pulses and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        // unmapped or read-only offsets answer with slave error
        s_axi_bresp <= (s_axi_awaddr == OFS_MCTL || s_axi_awaddr == OFS_SCRATCH ||
                        s_axi_awaddr == OFS_IEN) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel: one cycle from address to data
  assign rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  assign rd_ms = rd_go && (s_axi_araddr == OFS_MSTAT);
  assign rd_iir = rd_go && (s_axi_araddr == OFS_IIR);
  assign rd_ls = rd_go && (s_axi_araddr == OFS_LSTAT);

  // read data mux and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          OFS_MCTL: s_axi_rdata <= {24'h0, mc_q};
          OFS_MSTAT: s_axi_rdata <= {24'h0, mstat};
          OFS_SCRATCH: s_axi_rdata <= {24'h0, scratch_q};
          OFS_IIR: s_axi_rdata <= {28'h0, iir_code};
          OFS_LSTAT: s_axi_rdata <= {27'h0, lerr_q, 1'b0};
          OFS_IEN: s_axi_rdata <= {28'h0, ien_q};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, scratch and enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mc_q <= MC_RESET;
      scratch_q <= 8'h00;
      ien_q <= 4'h0;
    end else begin
      // reserved bits 5,6 masked off on store
      if (wr_mc) begin
        mc_q <= s_axi_wdata[7:0] & MC_WMASK;
      end
      // scratch is storage only
      if (wr_scr) begin
        scratch_q <= s_axi_wdata[7:0];
      end
      if (wr_ien) begin
        ien_q <= s_axi_wdata[3:0];
      end
    end
  end

  // control bits driven out from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      user_output_a_reset <= 1'b0;
      loopback_mode <= 1'b0;
      bank_select <= 1'b0;
      irq_output_oe <= 1'b0;
    end else begin
      user_output_a_reset <= mc_q[MC_RST];
      loopback_mode <= mc_q[MC_LOOP];
      bank_select <= mc_q[MC_BANK];
      irq_output_oe <= mc_q[MC_IRQEN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // terminal-ready loss timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dtr_st_q <= DTR_IDLE;
      dtr_cnt_q <= 32'h0;
      dtr_disconnect <= 1'b0;
    end else begin
      dtr_disconnect <= 1'b0;
      case (dtr_st_q)
        // wait for terminal-ready high, then watch for a fall
        DTR_IDLE: begin
          if (mc_q[MC_DTR] && wr_mc && !s_axi_wdata[MC_DTR]) begin
            dtr_st_q <= DTR_TIMING;
            dtr_cnt_q <= 32'h0;
          end
        end
        // count while held low; fire once past the hold time
        DTR_TIMING: begin
          if (mc_q[MC_DTR]) begin
            dtr_st_q <= DTR_IDLE;
          end else if (dtr_cnt_q == 32'(DTR_LOSS_CYCLES)) begin
            dtr_disconnect <= 1'b1;
            dtr_st_q <= DTR_DONE;
          end else begin
            dtr_cnt_q <= dtr_cnt_q + 32'h1;
          end
        end
        // sequence started; rearm once raised again
        DTR_DONE: begin
          if (mc_q[MC_DTR]) begin
            dtr_st_q <= DTR_IDLE;
          end
        end
        default: dtr_st_q <= DTR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carrier qualification
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cd_cnt_q <= 13'h0;
      cd_qual_q <= 1'b0;
    end else if (!carrier_valid) begin
      cd_cnt_q <= 13'h0;
      cd_qual_q <= 1'b0;
    end else if (cd_cnt_q == 13'(CD_ON_CYC)) begin
      cd_qual_q <= 1'b1;
    end else begin
      cd_cnt_q <= cd_cnt_q + 13'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // live status levels with loopback substitution
  always_comb begin
    cts_live = connect_done;
    dsr_live = mc_q[MC_LOOP] ? mc_q[MC_DTR] : power_up;
    ri_live = mc_q[MC_LOOP] ? mc_q[MC_RST] : !ring_in;
    if (mc_q[MC_LOOP]) begin
      cd_live = mc_q[MC_IRQEN];
    end else if (tone_detect_en) begin
      cd_live = tone_present;
    end else begin
      cd_live = cd_qual_q;
    end
  end

  assign mstat = {cd_live, ri_live, dsr_live, cts_live, delta_q};

  // change events this cycle
  assign delta_set[MS_CTS_CHANGED_FLAG] = cts_live != cts_prev_q;
  assign delta_set[MS_DSR_CHANGED_FLAG] = dsr_live != dsr_prev_q;
  assign delta_set[MS_RING_TRAILING_EDGE_FLAG] = ring_in && !ri_prev_q;
  assign delta_set[MS_DCD] = cd_live != cd_prev_q;

  // previous levels; track live levels in reset too, so release shows no false change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cts_prev_q <= cts_live;
      dsr_prev_q <= dsr_live;
      ri_prev_q <= ring_in;
      cd_prev_q <= cd_live;
    end else begin
      cts_prev_q <= cts_live;
      dsr_prev_q <= dsr_live;
      ri_prev_q <= ring_in;
      cd_prev_q <= cd_live;
    end
  end

  // sticky change flags; a new change beats the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delta_q <= 4'h0;
    end else begin
      delta_q <= (rd_ms ? 4'h0 : delta_q) | delta_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line error flags, cleared by reading them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lerr_q <= 4'h0;
    end else begin
      lerr_q <= (rd_ls ? 4'h0 : lerr_q) | line_err_pulse;
    end
  end

  // holding-empty pending: cleared by ident read while it is the source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thre_pend_q <= 1'b0;
    end else if (thre_set_pulse) begin
      thre_pend_q <= 1'b1;
    end else if (thr_write_pulse || (rd_iir && iir_code == IIR_THRE)) begin
      thre_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt priority encoder
  assign ls_pend = (lerr_q != 4'h0) && ien_q[IE_LS];
  assign ms_pend = (delta_q != 4'h0) && ien_q[IE_MS];

  always_comb begin
    if (ls_pend) begin
      iir_code = IIR_LS;
    end else if (rx_data_avail && ien_q[IE_RX]) begin
      iir_code = IIR_RX;
    end else if (thre_pend_q && ien_q[IE_THRE]) begin
      iir_code = IIR_THRE;
    end else if (ms_pend) begin
      iir_code = IIR_MS2;
    end else if (ms1_pending && ien_q[IE_MS]) begin
      iir_code = IIR_MS1;
    end else begin
      iir_code = IIR_NONE;
    end
  end

  // interrupt request level from flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_output <= 1'b0;
    end else begin
      irq_output <= !iir_code[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence dtr_dropped;
    wr_mc && mc_q[MC_DTR] && !s_axi_wdata[MC_DTR];
  endsequence

  sequence dtr_rises;
    !mc_q[MC_DTR] ##1 mc_q[MC_DTR];
  endsequence

  reserved_bits_a: assert property (mc_q[6:5] == 2'b00)
    else $error("reserved control bits not zero");
  irq_drive_a: assert property ($rose(mc_q[MC_IRQEN]) |=> irq_output_oe)
    else $error("interrupt output not enabled");
  dtr_loss_a: assert property (dtr_disconnect |->
    !$past(mc_q[MC_DTR]) && $past(dtr_st_q) == DTR_TIMING)
    else $error("disconnect without held low");
  dtr_arm_a: assert property (dtr_dropped |=> dtr_st_q == DTR_TIMING)
    else $error("loss timer not started");
  dtr_cancel_a: assert property (dtr_rises |=> !dtr_disconnect)
    else $error("disconnect after re-raise");
  cts_delta_a: assert property (cts_live != cts_prev_q |=> delta_q[MS_CTS_CHANGED_FLAG])
    else $error("clear-to-send change lost");
  ring_edge_a: assert property ($rose(ring_in) |=> delta_q[MS_RING_TRAILING_EDGE_FLAG])
    else $error("ring edge not flagged");
  status_clear_a: assert property (rd_ms && delta_set == 4'h0 |=> delta_q == 4'h0)
    else $error("status read did not clear");
  loop_dsr_a: assert property (mc_q[MC_LOOP] |-> mstat[MS_DSR] == mc_q[MC_DTR])
    else $error("loopback set-ready mismatch");
  pending_bit_a: assert property (ls_pend |-> iir_code == IIR_LS ##1 irq_output)
    else $error("line status not pending");
  lerr_clear_a: assert property (rd_ls && line_err_pulse == 4'h0 |=> lerr_q == 4'h0)
    else $error("line errors not cleared");

endmodule
`default_nettype wire

// ---- include/mcsr_pkg.sv ----
// constants for the modem control and status register bank
package mcsr_pkg;
  // clock and timing
  localparam int CLK_HZ = 100_000_000; // aclk rate
  localparam int DTR_LOSS_MS = 50; // terminal-ready low hold time, ms
  localparam int DTR_LOSS_CYC_DEF = DTR_LOSS_MS * (CLK_HZ / 1000); // cycles in 50 ms
  localparam int CD_ON_US = 10; // carrier-on qualify time, us
  localparam int CD_ON_CYC = CD_ON_US * (CLK_HZ / 1_000_000); // cycles in qualify time
  // register byte offsets
  localparam logic [7:0] OFS_MCTL = 8'h00; // modem_control_two
  localparam logic [7:0] OFS_MSTAT = 8'h04; // modem_status_two
  localparam logic [7:0] OFS_SCRATCH = 8'h08; // scratch_store
  localparam logic [7:0] OFS_IIR = 8'h0c; // interrupt_ident_reg
  localparam logic [7:0] OFS_LSTAT = 8'h10; // line error status
  localparam logic [7:0] OFS_IEN = 8'h14; // interrupt enables
  // control bit positions
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_RST = 2;
  localparam int MC_IRQEN = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_BANK = 7;
  localparam logic [7:0] MC_WMASK = 8'h9f; // bits 5,6 never stored
  localparam logic [7:0] MC_RESET = 8'h00;
  // status bit positions
  localparam int MS_CTS_CHANGED_FLAG = 0;
  localparam int MS_DSR_CHANGED_FLAG = 1;
  localparam int MS_RING_TRAILING_EDGE_FLAG = 2;
  localparam int MS_DCD = 3;
  localparam int MS_CTS = 4;
  localparam int MS_DSR = 5;
  localparam int MS_RI = 6;
  localparam int MS_CD = 7;
  // interrupt enable bits
  localparam int IE_RX = 0;
  localparam int IE_THRE = 1;
  localparam int IE_LS = 2;
  localparam int IE_MS = 3;
  // interrupt identification codes
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LS = 4'h6;
  localparam logic [3:0] IIR_RX = 4'h4;
  localparam logic [3:0] IIR_THRE = 4'h2;
  localparam logic [3:0] IIR_MS2 = 4'h0;
  localparam logic [3:0] IIR_MS1 = 4'h8;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // terminal-ready loss sequencer; one bit changes per step, two from DTR_DONE back to DTR_IDLE
  typedef enum logic [1:0] {
    DTR_IDLE = 2'b00,
    DTR_TIMING = 2'b01,
    DTR_DONE = 2'b11
  } mcsr_dtr_e;
endpackage

// ---- verification/mcsr_host.sv ----
// host model: axi4-lite bus master for the register bank
`timescale 1ns/1ps
`default_nettype none
module mcsr_host (
  // clock
  input wire logic aclk,
  // write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus; answers are always accepted
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
  end
  // one write; address and data each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
    bit ta;
    bit tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      s_axi_awvalid <= !ta;
      s_axi_wvalid <= !tw;
    end
    // response follows both channels
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
  endtask
  // one read; data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the modem control and status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); \
  end \
end
module tb
  import mcsr_pkg::*;
;
  localparam int DLC = 20; // shortened terminal-ready loss count
  // clock, reset, bus
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  // modem levels and interrupt sources
  logic connect_done, power_up, ring_in, carrier_valid, tone_detect_en, tone_present;
  logic [3:0] line_err_pulse;
  logic rx_data_avail, thre_set_pulse, thr_write_pulse, ms1_pending;
  // design outputs and resolved interrupt wire
  logic dtr_disconnect, user_output_a_reset, loopback_mode, bank_select;
  logic irq_output, irq_output_oe, irq_line;
  // bench state
  int num_errors, n_tests, n;
  logic [15:0] seed;
  logic [7:0] ctl;
  logic [31:0] d;
  logic [3:0] e;
  logic [1:0] r;
  assign irq_line = irq_output_oe ? irq_output : 1'bz;
  mcsr_regs #(.DTR_LOSS_CYCLES(DLC)) dut (.*);
  mcsr_host host (.*);
  // free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // pseudo-random source
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected live upper half of the status byte
  function automatic logic [3:0] live_hi(input logic [7:0] c, input logic cq);
    if (c[4])
      return {c[3], c[2], c[0], connect_done};
    return {tone_detect_en ? tone_present : cq, ~ring_in, power_up, connect_done};
  endfunction
  task automatic idle(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // read and compare under a mask; upper bits must read zero
  task automatic rdc(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    host.rd(a, d, r);
    `CHK(r, RESP_OKAY)
    `CHK(d & {24'hffffff, m}, {24'h000000, x & m})
  endtask
  // write, expect okay, track the control image
  task automatic wrc(input logic [7:0] a, input logic [7:0] v);
    host.wr(a, v, r);
    `CHK(r, RESP_OKAY)
    if (a == OFS_MCTL)
      ctl = v & 8'h9f;
  endtask
  // status read shows the deltas, second read shows them cleared
  task automatic st(input logic [3:0] dl, input logic cq);
    idle(3);
    rdc(OFS_MSTAT, {live_hi(ctl, cq), dl}, 8'hff);
    rdc(OFS_MSTAT, {live_hi(ctl, cq), 4'h0}, 8'hff);
  endtask
  // count edges until a disconnect pulse, at most lim
  task automatic wait_pulse(input int lim);
    n = 0;
    while (!dtr_disconnect && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask
  // verdict and end of run
  task automatic summarize;
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    summarize();
  end
  // main sequence
  initial begin
    aresetn = 1'b0;
    {connect_done, ring_in, carrier_valid, tone_detect_en, tone_present} = 5'h0;
    power_up = 1'b1;
    line_err_pulse = 4'h0;
    {rx_data_avail, thre_set_pulse, thr_write_pulse, ms1_pending} = 4'h0;
    seed = 16'h5139;
    ctl = 8'h00;
    num_errors = 0;
    n_tests = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(OFS_MCTL, 8'h00, 8'hff);
    idle(3);
    rdc(OFS_MSTAT, {live_hi(ctl, 1'b0), 4'h0}, 8'hff);
    // each modem level change in turn
    connect_done <= 1'b1;
    st(4'h1, 1'b0);
    power_up <= 1'b0;
    st(4'h2, 1'b0);
    ring_in <= 1'b1;
    st(4'h4, 1'b0);
    ring_in <= 1'b0;
    st(4'h0, 1'b0);
    tone_detect_en <= 1'b1;
    tone_present <= 1'b1;
    st(4'h8, 1'b0);
    tone_present <= 1'b0;
    st(4'h8, 1'b0);
    tone_detect_en <= 1'b0;
    carrier_valid <= 1'b1;
    idle(CD_ON_CYC / 2);
    rdc(OFS_MSTAT, 8'h00, 8'h80);
    idle(CD_ON_CYC / 2 + 10);
    st(4'h8, 1'b1);
    // control bits, reserved bits, loopback mirrors
    wrc(OFS_MCTL, 8'hff);
    rdc(OFS_MCTL, 8'h9f, 8'hff);
    `CHK({user_output_a_reset, irq_output_oe, loopback_mode, bank_select}, 4'hf)
    rdc(OFS_MSTAT, {live_hi(ctl, 1'b1), 4'h0}, 8'hf0);
    wrc(OFS_MCTL, 8'h00);
    idle(3);
    `CHK({user_output_a_reset, irq_output_oe, loopback_mode, bank_select}, 4'h0)
    rdc(OFS_MSTAT, {live_hi(ctl, 1'b1), 4'h2}, 8'hff);
    host.wr(OFS_MSTAT, 8'hff, r);
    `CHK(r, RESP_SLVERR)
    host.rd(8'h3c, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    // all interrupt levels, highest first
    wrc(OFS_IEN, 8'h0f);
    wrc(OFS_MCTL, 8'h08);
    seed = lfsr(seed);
    e = seed[3:0] | 4'h1;
    line_err_pulse <= e;
    thre_set_pulse <= 1'b1;
    rx_data_avail <= 1'b1;
    ms1_pending <= 1'b1;
    connect_done <= 1'b0;
    @(posedge aclk);
    line_err_pulse <= 4'h0;
    thre_set_pulse <= 1'b0;
    idle(3);
    `CHK(irq_line, 1'b1)
    rdc(OFS_IIR, 8'h06, 8'hff);
    rdc(OFS_LSTAT, {3'h0, e, 1'b0}, 8'hff);
    rdc(OFS_IIR, 8'h04, 8'hff);
    rx_data_avail <= 1'b0;
    idle(3);
    rdc(OFS_IIR, 8'h02, 8'hff);
    rdc(OFS_IIR, 8'h00, 8'hff);
    rdc(OFS_MSTAT, 8'h01, 8'h0f);
    rdc(OFS_IIR, 8'h08, 8'hff);
    ms1_pending <= 1'b0;
    idle(3);
    rdc(OFS_IIR, 8'h01, 8'hff);
    `CHK(irq_line, 1'b0)
    wrc(OFS_MCTL, 8'h00);
    idle(2);
    `CHK(irq_line, 1'bz)
    // scratch byte keeps random values
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wrc(OFS_SCRATCH, seed[7:0]);
      rdc(OFS_SCRATCH, seed[7:0], 8'hff);
    end
    // terminal-ready loss: one timed pulse, then a cancelled fall
    wrc(OFS_MCTL, 8'h01);
    wrc(OFS_MCTL, 8'h00);
    wait_pulse(60);
    `CHK(n, DLC + 1)
    @(posedge aclk);
    `CHK(dtr_disconnect, 1'b0)
    wrc(OFS_MCTL, 8'h01);
    wrc(OFS_MCTL, 8'h00);
    idle(5);
    wrc(OFS_MCTL, 8'h01);
    wait_pulse(40);
    `CHK(n, 40)
    summarize();
  end
endmodule
`default_nettype wire
